/* File: src/aies_edge_detect.sv */
`timescale 1ns/1ps

module aies_edge_detect
  import aies_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic level,
  output logic      edgePulse
);

  logic prevLevel;
  logic armed;
  logic next_prevLevel;
  logic next_armed;

  // ****************************************************************
  // Arms one cycle after reset so the first sample is no edge
  // ****************************************************************
  always_comb begin
    next_prevLevel = level;
    next_armed     = 1'b1;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prevLevel <= RST_FLAG;
      armed     <= RST_FLAG;
    end else begin
      prevLevel <= next_prevLevel;
      armed     <= next_armed;
    end
  end

  assign edgePulse = armed && (level != prevLevel);

endmodule : aies_edge_detect

/* File: src/aies_flag_if.sv */
`timescale 1ns/1ps

interface aies_flag_if;
  logic set;
  logic clr;
  logic value;

  modport owner (input set, input clr, output value);
  modport user  (output set, output clr, input value);
endinterface : aies_flag_if

/* File: src/aies_pkg.sv */
package aies_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int         ADDR_W          = 6;
  localparam int         DATA_W          = 8;
  localparam logic [5:0] ADDR_SEC_ENABLE = 6'h03;
  localparam logic [5:0] ADDR_SEC_FLAGS  = 6'h05;
  localparam logic [5:0] ADDR_ERROR      = 6'h06;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_SEC_ENABLE  = 8'h00;
  localparam logic [7:0] RST_SEC_FLAGS   = 8'h00;
  localparam logic [7:0] RST_ERROR       = 8'h00;
  localparam logic [7:0] RST_READ_DATA   = 8'h00;
  localparam logic       RST_FLAG        = 1'b0;

  // ****************************************************************
  // Secondary flag and enable fields
  // ****************************************************************
  localparam int         SEC_SELECT_BIT  = 7;
  localparam int         SEC_PUSHPULL_BIT = 7;
  localparam int         SEC_AUX_BIT     = 4;
  localparam int         SEC_CSUM_BIT    = 2;
  localparam logic [7:0] SEC_FLAG_MASK   = 8'h14;
  localparam logic [7:0] SEC_ENABLE_MASK = 8'h94;

  // ****************************************************************
  // Error flag fields
  // ****************************************************************
  localparam int         ERR_HOST_WRITE  = 7;
  localparam int         ERR_OVERHEAT    = 6;
  localparam int         ERR_RESERVED    = 5;
  localparam int         ERR_FIFO_FULL   = 4;
  localparam int         ERR_COLLISION   = 3;
  localparam int         ERR_CHECKSUM    = 2;
  localparam int         ERR_PARITY      = 1;
  localparam int         ERR_FRAME       = 0;
  localparam int         ERR_COUNT       = 8;
  localparam logic [7:0] ERR_RX_MASK     = 8'h0F;
  localparam logic [7:0] ERR_CMD_MASK    = 8'hBF;

endpackage : aies_pkg

/* File: src/aies_sticky_flag.sv */
`timescale 1ns/1ps

module aies_sticky_flag
  import aies_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   reset_n,
  aies_flag_if.owner  port
);

  logic flag;
  logic next_flag;

  // ****************************************************************
  // Set dominates clear, otherwise hold
  // ****************************************************************
  always_comb begin
    next_flag = flag;
    if (port.set) begin
      next_flag = 1'b1;
    end else if (port.clr) begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      flag <= RST_FLAG;
    end else begin
      flag <= next_flag;
    end
  end

  assign port.value = flag;

endmodule : aies_sticky_flag

/* File: src/aux_irq_and_error_status.sv */
`timescale 1ns/1ps

module aux_irq_and_error_status
  import aies_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  input  wire logic [DATA_W-1:0] regWriteData,
  output logic      [DATA_W-1:0] regReadData,
  input  wire logic              auxSerialInput,
  input  wire logic              checksumCalcRunning,
  input  wire logic              checksumDataDone,
  input  wire logic              hostFifoWrite,
  input  wire logic              authRunning,
  input  wire logic              txRxGap,
  input  wire logic              overheatDetect,
  input  wire logic              overheatClear,
  input  wire logic              fifoFullWrite,
  input  wire logic              rateIsLowest,
  input  wire logic              bitCollision,
  input  wire logic              rxChecksumEnable,
  input  wire logic              rxChecksumBad,
  input  wire logic              parityFail,
  input  wire logic              frameStartBad,
  input  wire logic              authByteCountBad,
  input  wire logic              rxStartup,
  input  wire logic              commandStart,
  output logic      [DATA_W-1:0] errorFlags,
  output logic      [DATA_W-1:0] secondaryFlags,
  output logic                   errorEvent,
  output logic                   secondaryIrqRequest,
  output logic                   irqPushPull,
  output logic                   antennaDriversOff
);

  // ****************************************************************
  // Register access decode
  // ****************************************************************
  logic wrSecFlags;
  logic wrSecEnable;
  logic swSelect;

  assign wrSecFlags  = regWrite && (regAddr == ADDR_SEC_FLAGS);
  assign wrSecEnable = regWrite && (regAddr == ADDR_SEC_ENABLE);
  assign swSelect    = regWriteData[SEC_SELECT_BIT];

  // ****************************************************************
  // Secondary enable register
  // ****************************************************************
  logic [DATA_W-1:0] secEnable;
  logic [DATA_W-1:0] next_secEnable;

  always_comb begin
    next_secEnable = secEnable;
    if (wrSecEnable) begin
      next_secEnable = regWriteData & SEC_ENABLE_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      secEnable <= RST_SEC_ENABLE;
    end else begin
      secEnable <= next_secEnable;
    end
  end

  assign irqPushPull = secEnable[SEC_PUSHPULL_BIT];

  // ****************************************************************
  // Secondary event flags
  // ****************************************************************
  logic auxEdge;
  logic auxFlag;
  logic csumFlag;
  logic csumDone;

  aies_flag_if auxIf ();
  aies_flag_if csumIf ();

  aies_edge_detect u_aux_edge (
    .clock     (clock),
    .reset_n   (reset_n),
    .level     (auxSerialInput),
    .edgePulse (auxEdge)
  );

  assign csumDone = checksumCalcRunning && checksumDataDone;

  assign auxIf.set  = auxEdge ||
                      (wrSecFlags && swSelect && regWriteData[SEC_AUX_BIT]);
  assign auxIf.clr  = wrSecFlags && !swSelect && regWriteData[SEC_AUX_BIT];
  assign csumIf.set = csumDone ||
                      (wrSecFlags && swSelect && regWriteData[SEC_CSUM_BIT]);
  assign csumIf.clr = wrSecFlags && !swSelect && regWriteData[SEC_CSUM_BIT];

  aies_sticky_flag u_aux_flag (
    .clock   (clock),
    .reset_n (reset_n),
    .port    (auxIf.owner)
  );

  aies_sticky_flag u_csum_flag (
    .clock   (clock),
    .reset_n (reset_n),
    .port    (csumIf.owner)
  );

  assign auxFlag  = auxIf.value;
  assign csumFlag = csumIf.value;

  always_comb begin
    secondaryFlags               = RST_SEC_FLAGS;
    secondaryFlags[SEC_AUX_BIT]  = auxFlag;
    secondaryFlags[SEC_CSUM_BIT] = csumFlag;
  end

  // ****************************************************************
  // Error flag set and clear terms
  // ****************************************************************
  logic [ERR_COUNT-1:0] errSet;
  logic [ERR_COUNT-1:0] errClr;
  logic [ERR_COUNT-1:0] errValue;

  always_comb begin
    errSet                 = '0;
    errSet[ERR_HOST_WRITE] = hostFifoWrite && (authRunning || txRxGap);
    errSet[ERR_OVERHEAT]   = overheatDetect;
    errSet[ERR_FIFO_FULL]  = fifoFullWrite;
    errSet[ERR_COLLISION]  = bitCollision && rateIsLowest;
    errSet[ERR_CHECKSUM]   = rxChecksumEnable && rxChecksumBad;
    errSet[ERR_PARITY]     = parityFail && rateIsLowest;
    errSet[ERR_FRAME]      = (frameStartBad && rateIsLowest) ||
                             (authRunning && authByteCountBad);
    errClr = '0;
    if (rxStartup) begin
      errClr = errClr | ERR_RX_MASK;
    end
    if (commandStart) begin
      errClr = errClr | ERR_CMD_MASK;
    end
    errClr[ERR_OVERHEAT]  = overheatClear;
    errClr[ERR_COLLISION] = errClr[ERR_COLLISION] || !rateIsLowest;
  end

  // One sticky cell per error bit; the reserved cell is never set
  aies_flag_if errIf [ERR_COUNT] ();

  for (genvar i = 0; i < ERR_COUNT; i++) begin : g_err
    assign errIf[i].set = (i == ERR_RESERVED) ? 1'b0 : errSet[i];
    assign errIf[i].clr = errClr[i];
    assign errValue[i]  = errIf[i].value;
    aies_sticky_flag u_err_flag (
      .clock   (clock),
      .reset_n (reset_n),
      .port    (errIf[i].owner)
    );
  end

  assign errorFlags        = errValue;
  assign antennaDriversOff = errValue[ERR_OVERHEAT];

  // ****************************************************************
  // Event and request outputs
  // ****************************************************************
  logic errEvt;
  logic secReq;
  logic next_errEvt;
  logic next_secReq;

  always_comb begin
    next_errEvt = |errValue;
    next_secReq = (csumFlag && secEnable[SEC_CSUM_BIT]) ||
                  (auxFlag && secEnable[SEC_AUX_BIT]);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      errEvt <= RST_FLAG;
      secReq <= RST_FLAG;
    end else begin
      errEvt <= next_errEvt;
      secReq <= next_secReq;
    end
  end

  assign errorEvent          = errEvt;
  assign secondaryIrqRequest = secReq;

  // ****************************************************************
  // Read data; error register ignores writes
  // ****************************************************************
  logic [DATA_W-1:0] rdData;
  logic [DATA_W-1:0] next_rdData;

  always_comb begin
    next_rdData = rdData;
    if (regRead) begin
      case (regAddr)
        ADDR_SEC_ENABLE: begin
          next_rdData = secEnable;
        end
        ADDR_SEC_FLAGS: begin
          next_rdData = secondaryFlags;
        end
        ADDR_ERROR: begin
          next_rdData = errValue;
        end
        default: begin
          next_rdData = RST_READ_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdData <= RST_READ_DATA;
    end else begin
      rdData <= next_rdData;
    end
  end

  assign regReadData = rdData;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  chk_select_sets_bits: assert property (
    wrSecFlags && swSelect && regWriteData[SEC_AUX_BIT] |=> secondaryFlags[SEC_AUX_BIT])
    else $error("select one did not set aux flag");

  chk_select_clears_bits: assert property (
    wrSecFlags && !swSelect && regWriteData[SEC_CSUM_BIT] && !csumDone
    |=> !secondaryFlags[SEC_CSUM_BIT])
    else $error("select zero did not clear checksum flag");

  chk_no_self_clear: assert property (
    $fell(secondaryFlags[SEC_AUX_BIT]) |->
    $past(wrSecFlags) && !$past(swSelect) && $past(regWriteData[SEC_AUX_BIT]))
    else $error("aux flag cleared without software");

  chk_aux_edge_sets: assert property (
    $past(reset_n) && $changed(auxSerialInput) |=> secondaryFlags[SEC_AUX_BIT])
    else $error("aux input edge missed");

  chk_csum_done_sets: assert property (
    checksumCalcRunning && checksumDataDone |=> secondaryFlags[SEC_CSUM_BIT])
    else $error("checksum done not flagged");

  chk_host_write_err: assert property (
    hostFifoWrite && (authRunning || txRxGap) |=> errorFlags[ERR_HOST_WRITE])
    else $error("host write violation not flagged");

  chk_overheat_antenna: assert property (
    overheatDetect |=> errorFlags[ERR_OVERHEAT] && antennaDriversOff)
    else $error("overheat not flagged or antenna still on");

  chk_fifo_overflow: assert property (
    fifoFullWrite |=> errorFlags[ERR_FIFO_FULL])
    else $error("full fifo write not flagged");

  chk_collision_high_rate: assert property (
    !rateIsLowest |=> !errorFlags[ERR_COLLISION])
    else $error("collision flag set at high rate");

  chk_frame_byte_count: assert property (
    authRunning && authByteCountBad |=> errorFlags[ERR_FRAME])
    else $error("byte count error not flagged");

  chk_startup_clears: assert property (
    rxStartup && ((errSet & ERR_RX_MASK) == 8'h00) |=>
    ((errorFlags & ERR_RX_MASK) == 8'h00))
    else $error("receiver start-up left rx errors set");

  chk_cmd_keeps_heat: assert property (
    commandStart && !overheatClear && !overheatDetect |=>
    errorFlags[ERR_OVERHEAT] == $past(errorFlags[ERR_OVERHEAT]))
    else $error("command start changed overheat flag");

  chk_reserved_zero: assert property (
    !errorFlags[ERR_RESERVED] && ((secondaryFlags & ~SEC_FLAG_MASK) == 8'h00))
    else $error("reserved bit not zero");

  chk_error_event: assert property (
    (|errorFlags) |=> errorEvent)
    else $error("error event not raised");

  chk_irq_gating: assert property (
    secondaryIrqRequest |->
    $past(secondaryFlags[SEC_CSUM_BIT] && secEnable[SEC_CSUM_BIT]) ||
    $past(secondaryFlags[SEC_AUX_BIT] && secEnable[SEC_AUX_BIT]))
    else $error("request without enabled event");

  chk_set_beats_clear: assert property (
    fifoFullWrite && commandStart |=> errorFlags[ERR_FIFO_FULL])
    else $error("clear won over hardware set");

  cov_aux_request: cover property (
    auxEdge && secEnable[SEC_AUX_BIT] ##2 secondaryIrqRequest);

  cov_csum_clear: cover property (
    secondaryFlags[SEC_CSUM_BIT] ##1 wrSecFlags && !swSelect ##1 !secondaryFlags[SEC_CSUM_BIT]);

  cov_error_read: cover property (
    errorEvent ##1 regRead && regAddr == ADDR_ERROR);

endmodule : aux_irq_and_error_status

/* File: tb/aies_host_model.sv */
`timescale 1ns/1ps

module aies_host_model
  import aies_pkg::*;
(
  input  wire logic              clock,
  output logic      [ADDR_W-1:0] regAddr,
  output logic                   regWrite,
  output logic                   regRead,
  output logic      [DATA_W-1:0] regWriteData
);
  // ****************************************************************
  // Register bus cycles of the host
  // ****************************************************************
  initial begin
    regAddr      = '0;
    regWrite     = 1'b0;
    regRead      = 1'b0;
    regWriteData = '0;
  end

  // Event bits are cleared only by these host writes
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    regAddr      <= a;
    regWriteData <= d;
    regWrite     <= 1'b1;
    @(posedge clock);
    regWrite     <= 1'b0;
    regAddr      <= ~a;
    regWriteData <= ~d;
  endtask : wr

  // Released address shows the inverse, never a stale value
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    regAddr <= ~a;
  endtask : rd
endmodule : aies_host_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
  import aies_pkg::*;
  // ****************************************************************
  // Stimulus and bookkeeping
  // ****************************************************************
  logic              clock, reset_n, auxSerialInput, checksumCalcRunning;
  logic              hostFifoWrite, authRunning, txRxGap, overheatDetect, overheatClear;
  logic              fifoFullWrite, rateIsLowest, bitCollision, rxChecksumEnable;
  logic              rxChecksumBad, parityFail, frameStartBad, authByteCountBad;
  logic              rxStartup, commandStart, checksumDataDone, regWrite, regRead;
  logic              errorEvent, secondaryIrqRequest, irqPushPull, antennaDriversOff;
  logic              rdPend;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWriteData, regReadData, errorFlags, secondaryFlags;
  logic [DATA_W-1:0] expErr, expSec, expEn;
  logic [11:0]       pls;
  logic [27:0]       exp, got;
  logic [3:0]        lvl;
  logic [27:0]       notes[$];
  logic [31:0]       seed;
  int                n_mismatch, compares;

  localparam logic [23:0] ERRT [14] = '{
    24'h4_001_80, 24'h8_001_80, 24'h0_001_00, 24'h0_002_10,
    24'h1_004_08, 24'h0_004_00, 24'h2_008_04, 24'h0_008_00,
    24'h1_010_02, 24'h0_010_00, 24'h1_020_01, 24'h0_020_00,
    24'h4_040_01, 24'h0_200_40};

  assign {checksumDataDone, overheatClear, overheatDetect, commandStart, rxStartup,
          authByteCountBad, frameStartBad, parityFail, rxChecksumBad, bitCollision,
          fifoFullWrite, hostFifoWrite} = pls;
  assign {txRxGap, authRunning, rxChecksumEnable, rateIsLowest} = lvl;

  aies_host_model u_aies_host_model (.clock, .regAddr, .regWrite, .regRead, .regWriteData);

  aux_irq_and_error_status u_aux_irq_and_error_status (
    .clock, .reset_n, .regAddr, .regWrite, .regRead, .regWriteData, .regReadData,
    .auxSerialInput, .checksumCalcRunning, .checksumDataDone, .hostFifoWrite,
    .authRunning, .txRxGap, .overheatDetect, .overheatClear, .fifoFullWrite,
    .rateIsLowest, .bitCollision, .rxChecksumEnable, .rxChecksumBad, .parityFail,
    .frameStartBad, .authByteCountBad, .rxStartup, .commandStart, .errorFlags,
    .secondaryFlags, .errorEvent, .secondaryIrqRequest, .irqPushPull, .antennaDriversOff);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic pulse(input logic [11:0] m);
    @(posedge clock);
    pls <= m;
    @(posedge clock);
    pls <= '0;
  endtask : pulse

  // Notes the expected read data and status outputs, then reads
  task automatic chk(input logic [ADDR_W-1:0] a);
    logic [7:0] d;
    d = (a == ADDR_ERROR) ? expErr : (a == ADDR_SEC_FLAGS) ? expSec :
        (a == ADDR_SEC_ENABLE) ? expEn : 8'h00;
    repeat (2) @(posedge clock);
    notes.push_back({expEn[7], expErr[6], |expErr, |(expSec & expEn & SEC_FLAG_MASK),
                     expErr, expSec, d});
    u_aies_host_model.rd(a);
  endtask : chk

  task automatic end_of_test;
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // Output watcher
  // ****************************************************************
  always @(posedge clock) begin
    if (rdPend) begin
      exp = (notes.size() > 0) ? notes.pop_front() : 'x;
      got = {irqPushPull, antennaDriversOff, errorEvent, secondaryIrqRequest,
             errorFlags, secondaryFlags, regReadData};
      compares++;
      if (got !== exp) begin
        $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
        n_mismatch++;
      end
    end
    rdPend <= regRead;
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_of_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0]       r;
    logic [ADDR_W-1:0] a;
    reset_n = 1'b0;
    {auxSerialInput, checksumCalcRunning, pls, lvl} = '0;
    {expErr, expSec, expEn} = '0;
    seed = 32'd21;
    n_mismatch = 0;
    compares = 0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    chk(ADDR_ERROR);
    chk(ADDR_SEC_FLAGS);
    chk(6'h3F);
    u_aies_host_model.wr(ADDR_SEC_ENABLE, 8'hFF);
    expEn = SEC_ENABLE_MASK;
    u_aies_host_model.wr(6'h3F, 8'h00);
    chk(ADDR_SEC_ENABLE);
    @(posedge clock);
    auxSerialInput <= 1'b1;
    expSec = 8'h10;
    chk(ADDR_SEC_FLAGS);
    u_aies_host_model.wr(ADDR_SEC_FLAGS, 8'h10);
    expSec = 8'h00;
    chk(ADDR_SEC_FLAGS);
    @(posedge clock);
    auxSerialInput <= 1'b0;
    expSec = 8'h10;
    pulse(12'h800);
    chk(ADDR_SEC_FLAGS);
    @(posedge clock);
    checksumCalcRunning <= 1'b1;
    pulse(12'h800);
    @(posedge clock);
    checksumCalcRunning <= 1'b0;
    expSec = 8'h14;
    chk(ADDR_SEC_FLAGS);
    u_aies_host_model.wr(ADDR_SEC_FLAGS, 8'h14);
    expSec = 8'h00;
    chk(ADDR_SEC_FLAGS);
    u_aies_host_model.wr(ADDR_SEC_FLAGS, 8'h94);
    expSec = 8'h14;
    chk(ADDR_SEC_FLAGS);
    for (int i = 0; i < 12; i++) begin
      r = xs();
      a = r[8] ? ADDR_SEC_ENABLE : ADDR_SEC_FLAGS;
      u_aies_host_model.wr(a, r[7:0]);
      if (r[8]) expEn = r[7:0] & SEC_ENABLE_MASK;
      else if (r[7]) expSec = expSec | (r[7:0] & SEC_FLAG_MASK);
      else expSec = expSec & ~(r[7:0] & SEC_FLAG_MASK);
      chk(a);
    end
    foreach (ERRT[i]) begin
      pulse(12'h100);
      @(posedge clock);
      lvl <= ERRT[i][23:20];
      pulse(ERRT[i][19:8]);
      expErr = ERRT[i][7:0];
      chk(ADDR_ERROR);
      @(posedge clock);
      lvl <= 4'h0;
    end
    @(posedge clock);
    lvl <= 4'h7;
    pulse(12'h03F);
    expErr = 8'hDF;
    chk(ADDR_ERROR);
    pulse(12'h080);
    expErr = 8'hD0;
    chk(ADDR_ERROR);
    pulse(12'h100);
    expErr = 8'h40;
    u_aies_host_model.wr(ADDR_ERROR, 8'hFF);
    chk(ADDR_ERROR);
    pulse(12'h400);
    expErr = 8'h00;
    chk(ADDR_ERROR);
    pulse(12'h102);
    expErr = 8'h10;
    chk(ADDR_ERROR);
    pulse(12'h184);
    expErr = 8'h08;
    chk(ADDR_ERROR);
    @(posedge clock);
    lvl <= 4'h0;
    expErr = 8'h00;
    chk(ADDR_ERROR);
    chk(ADDR_SEC_FLAGS);
    for (int i = 0; i < 10 && notes.size() > 0; i++) @(posedge clock);
    if (notes.size() > 0) n_mismatch++;
    end_of_test();
  end
endmodule : tb_top
